// *** design/alsc_pkg.sv ***
// Package of constants and types for the ambient light ADC configuration
package alsc_pkg;

	// ----------------------------------------------------------------
	// Register offsets
	// ----------------------------------------------------------------
	localparam logic [7:0] OFS_VIS_GAIN  = 8'h11;
	localparam logic [7:0] OFS_VISIBLE_SIGNAL_RANGE = 8'h12;
	localparam logic [7:0] OFS_LED_RECOVERY_PARAM   = 8'h1C;
	localparam logic [7:0] OFS_IR_REC    = 8'h1D;
	localparam logic [7:0] OFS_IR_GAIN   = 8'h1E;
	localparam logic [7:0] OFS_STATUS    = 8'h20;
	localparam logic [7:0] OFS_CONTROL   = 8'h21;

	// ----------------------------------------------------------------
	// Field positions
	// ----------------------------------------------------------------
	localparam int GAIN_LSB     = 0;
	localparam int RANGE_BIT    = 5;
	localparam int REC_LSB      = 4;
	localparam int CTL_VIS_BIT  = 0;
	localparam int CTL_IR_BIT   = 1;
	localparam int STA_BUSY_BIT = 0;
	localparam int STA_INTG_BIT = 1;
	localparam int STA_IR_BIT   = 2;

	// ----------------------------------------------------------------
	// Reset values
	// ----------------------------------------------------------------
	localparam logic [7:0] RST_VIS_GAIN  = 8'h00;
	localparam logic [7:0] RST_VISIBLE_SIGNAL_RANGE = 8'h00;
	localparam logic [7:0] RST_LED_RECOVERY_PARAM   = 8'h00;
	localparam logic [7:0] RST_IR_REC    = 8'h70;
	localparam logic [7:0] RST_IR_GAIN   = 8'h00;

	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int CLK_PERIOD_NS = 8;
	localparam int ADC_BASE_NS   = 50;
	localparam int ADC_BASE_CYC  =
		(ADC_BASE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam logic [8:0] INTEG_ADC_CLKS = 9'h040;
	localparam logic [2:0] VIS_REC_CODE   = 3'h0;

	// ----------------------------------------------------------------
	// Types
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		ST_IDLE,
		ST_RECOVER,
		ST_INTEG
	} alsc_state_e;

	typedef struct packed {
		logic [2:0] gain;
		logic       high_range;
		logic [2:0] rec_code;
		logic       ir;
	} alsc_cfg_s;

	// ----------------------------------------------------------------
	// Functions
	// ----------------------------------------------------------------
	// Recovery length in ADC clocks for a three-bit code
	function automatic logic [8:0] rec_len(input logic [2:0] code);
		logic [9:0] v;
		v = 10'h000;
		if (code == 3'h0) begin
			v = 10'h001;
		end else begin
			v = (10'h004 << code) - 10'h001;
		end
		return v[8:0];
	endfunction

	// Main clock cycles in one divided ADC clock
	function automatic logic [9:0] adc_div_cycles(input logic [2:0] gain);
		logic [9:0] b;
		b = 10'(ADC_BASE_CYC);
		return b << gain;
	endfunction

endpackage

// *** design/alsc_clkdiv.sv ***
// ADC clock divider giving one tick per divided ADC clock
`timescale 1ns/100ps
`default_nettype none

module alsc_clkdiv (
	input  wire logic       i_mclk,
	input  wire logic       i_rst,
	input  wire logic       i_run,
	input  wire logic [2:0] i_gain,
	output logic            o_tick
);

	logic [9:0] cnt_r;
	logic [9:0] cnt_nxt;
	logic       tick_r;
	logic       tick_nxt;
	logic [9:0] lim;

	// Count base period times two to the gain
	always_comb begin
		lim      = alsc_pkg::adc_div_cycles(i_gain) - 10'h001;
		cnt_nxt  = 10'h000;
		tick_nxt = 1'b0;
		if (i_run) begin
			if (cnt_r == lim) begin
				tick_nxt = 1'b1;
			end else begin
				cnt_nxt = cnt_r + 10'h001;
			end
		end
	end

	// Registers
	always_ff @(posedge i_mclk or posedge i_rst) begin
		if (i_rst) begin
			cnt_r  <= 10'h000;
			tick_r <= 1'b0;
		end else begin
			cnt_r  <= cnt_nxt;
			tick_r <= tick_nxt;
		end
	end

	assign o_tick = tick_r;

endmodule

`default_nettype wire

// *** design/alsc_count.sv ***
// Down counter of ADC clocks for recovery and integration phases
`timescale 1ns/100ps
`default_nettype none

module alsc_count (
	input  wire logic       i_mclk,
	input  wire logic       i_rst,
	input  wire logic       i_load,
	input  wire logic [8:0] i_len,
	input  wire logic       i_tick,
	output logic            o_last
);

	logic [8:0] cnt_r;
	logic [8:0] cnt_nxt;

	// Load wins over a tick in the same cycle
	always_comb begin
		cnt_nxt = cnt_r;
		if (i_load) begin
			cnt_nxt = i_len;
		end else if (i_tick && (cnt_r != 9'h000)) begin
			cnt_nxt = cnt_r - 9'h001;
		end
	end

	// Registers
	always_ff @(posedge i_mclk or posedge i_rst) begin
		if (i_rst) begin
			cnt_r <= 9'h000;
		end else begin
			cnt_r <= cnt_nxt;
		end
	end

	// Final tick of the phase; load is made from this, so it stays out
	assign o_last = i_tick && (cnt_r == 9'h001);

endmodule

`default_nettype wire

// *** design/alsc_top.sv ***
// Ambient light ADC configuration registers and measurement sequencer
//
// Function
// - Visible integration time scales by two to gain
// - Visible gain codes reach seven, factor 128
// - ADC clock divided by two to gain
// - Range bit five selects high signal range for visible measurements
// - Early revisions: infrared uses visible gain, range
// - Infrared waits recovery period before measuring
// - Recovery codes decode to 1 through 511
// - Infrared recovery field resets to code seven
// - Infrared recovery parameter exists on later revisions
// - Later revisions use separate infrared gain
`timescale 1ns/100ps
`default_nettype none

module alsc_top #(
	parameter bit LATER_REV = 1'b1
) (
	input  wire logic       i_mclk,
	input  wire logic       i_rst,
	input  wire logic [7:0] i_addr,
	input  wire logic [7:0] i_wdata,
	input  wire logic       i_wr,
	input  wire logic       i_rd,
	output logic      [7:0] o_rdata,
	output logic            o_adc_tick,
	output logic            o_busy,
	output logic            o_integrate,
	output logic            o_ir_meas,
	output logic            o_high_range,
	output logic      [2:0] o_gain,
	output logic            o_done
);

	// ----------------------------------------------------------------
	// Parameter registers
	// ----------------------------------------------------------------
	logic [2:0] vis_gain_r;
	logic [2:0] vis_gain_nxt;
	logic       visible_signal_range_r;
	logic       visible_signal_range_nxt;
	logic [7:0] led_recovery_param_r;
	logic [7:0] led_recovery_param_nxt;
	logic [2:0] ir_rec_r;
	logic [2:0] ir_rec_nxt;
	logic [2:0] ir_gain_r;
	logic [2:0] ir_gain_nxt;
	logic [7:0] rdata_r;
	logic [7:0] rdata_nxt;
	logic       start_vis;
	logic       start_ir;

	// Register writes; reserved bits are not stored
	always_comb begin
		vis_gain_nxt  = vis_gain_r;
		visible_signal_range_nxt = visible_signal_range_r;
		led_recovery_param_nxt   = led_recovery_param_r;
		ir_rec_nxt    = ir_rec_r;
		ir_gain_nxt   = ir_gain_r;
		if (i_wr) begin
			case (i_addr)
				alsc_pkg::OFS_VIS_GAIN: begin
					vis_gain_nxt = i_wdata[alsc_pkg::GAIN_LSB +: 3];
				end
				alsc_pkg::OFS_VISIBLE_SIGNAL_RANGE: begin
					visible_signal_range_nxt = i_wdata[alsc_pkg::RANGE_BIT];
				end
				alsc_pkg::OFS_LED_RECOVERY_PARAM: begin
					led_recovery_param_nxt = i_wdata;
				end
				alsc_pkg::OFS_IR_REC: begin
					if (LATER_REV) begin
						ir_rec_nxt = i_wdata[alsc_pkg::REC_LSB +: 3];
					end
				end
				alsc_pkg::OFS_IR_GAIN: begin
					if (LATER_REV) begin
						ir_gain_nxt = i_wdata[alsc_pkg::GAIN_LSB +: 3];
					end
				end
				default: ;
			endcase
		end
	end

	// Start strobes from the control register
	assign start_vis = i_wr && (i_addr == alsc_pkg::OFS_CONTROL) &&
		i_wdata[alsc_pkg::CTL_VIS_BIT];
	assign start_ir  = i_wr && (i_addr == alsc_pkg::OFS_CONTROL) &&
		i_wdata[alsc_pkg::CTL_IR_BIT];

	// Read mux; data stand one cycle after the strobe only
	always_comb begin
		rdata_nxt = 8'h00;
		if (i_rd) begin
			case (i_addr)
				alsc_pkg::OFS_VIS_GAIN: begin
					rdata_nxt[alsc_pkg::GAIN_LSB +: 3] = vis_gain_r;
				end
				alsc_pkg::OFS_VISIBLE_SIGNAL_RANGE: begin
					rdata_nxt[alsc_pkg::RANGE_BIT] = visible_signal_range_r;
				end
				alsc_pkg::OFS_LED_RECOVERY_PARAM: begin
					rdata_nxt = led_recovery_param_r;
				end
				alsc_pkg::OFS_IR_REC: begin
					if (LATER_REV) begin
						rdata_nxt[alsc_pkg::REC_LSB +: 3] = ir_rec_r;
					end
				end
				alsc_pkg::OFS_IR_GAIN: begin
					if (LATER_REV) begin
						rdata_nxt[alsc_pkg::GAIN_LSB +: 3] = ir_gain_r;
					end
				end
				alsc_pkg::OFS_STATUS: begin
					rdata_nxt[alsc_pkg::STA_BUSY_BIT] = o_busy;
					rdata_nxt[alsc_pkg::STA_INTG_BIT] = o_integrate;
					rdata_nxt[alsc_pkg::STA_IR_BIT]   = o_ir_meas;
				end
				default: ;
			endcase
		end
	end

	// Parameter and read data registers
	always_ff @(posedge i_mclk or posedge i_rst) begin
		if (i_rst) begin
			vis_gain_r  <= alsc_pkg::RST_VIS_GAIN[2:0];
			visible_signal_range_r <= alsc_pkg::RST_VISIBLE_SIGNAL_RANGE[alsc_pkg::RANGE_BIT];
			led_recovery_param_r   <= alsc_pkg::RST_LED_RECOVERY_PARAM;
			ir_rec_r    <= alsc_pkg::RST_IR_REC[6:4];
			ir_gain_r   <= alsc_pkg::RST_IR_GAIN[2:0];
			rdata_r     <= 8'h00;
		end else begin
			vis_gain_r  <= vis_gain_nxt;
			visible_signal_range_r <= visible_signal_range_nxt;
			led_recovery_param_r   <= led_recovery_param_nxt;
			ir_rec_r    <= ir_rec_nxt;
			ir_gain_r   <= ir_gain_nxt;
			rdata_r     <= rdata_nxt;
		end
	end

	assign o_rdata = rdata_r;

	// ----------------------------------------------------------------
	// Measurement sequencer
	// ----------------------------------------------------------------
	alsc_pkg::alsc_state_e state_r;
	alsc_pkg::alsc_state_e state_nxt;
	alsc_pkg::alsc_cfg_s   cfg_r;
	alsc_pkg::alsc_cfg_s   cfg_nxt;
	logic                  done_r;
	logic                  done_nxt;
	logic                  load;
	logic [8:0]            len;
	logic                  last;
	logic                  tick;

	// Capture the active settings at start, then walk the phases
	always_comb begin
		state_nxt = state_r;
		cfg_nxt   = cfg_r;
		done_nxt  = 1'b0;
		load      = 1'b0;
		len       = alsc_pkg::INTEG_ADC_CLKS;
		case (state_r)
			alsc_pkg::ST_IDLE: begin
				if (start_vis) begin
					cfg_nxt.gain       = vis_gain_r;
					cfg_nxt.high_range = visible_signal_range_r;
					cfg_nxt.rec_code   = alsc_pkg::VIS_REC_CODE;
					cfg_nxt.ir         = 1'b0;
				end else if (start_ir) begin
					cfg_nxt.ir = 1'b1;
					if (LATER_REV) begin
						cfg_nxt.gain       = ir_gain_r;
						cfg_nxt.high_range = 1'b0;
						cfg_nxt.rec_code   = ir_rec_r;
					end else begin
						cfg_nxt.gain       = vis_gain_r;
						cfg_nxt.high_range = visible_signal_range_r;
						cfg_nxt.rec_code   = alsc_pkg::RST_IR_REC[6:4];
					end
				end
				if (start_vis || start_ir) begin
					state_nxt = alsc_pkg::ST_RECOVER;
					load      = 1'b1;
					len       = alsc_pkg::rec_len(cfg_nxt.rec_code);
				end
			end
			alsc_pkg::ST_RECOVER: begin
				if (last) begin
					state_nxt = alsc_pkg::ST_INTEG;
					load      = 1'b1;
					len       = alsc_pkg::INTEG_ADC_CLKS;
				end
			end
			alsc_pkg::ST_INTEG: begin
				if (last) begin
					state_nxt = alsc_pkg::ST_IDLE;
					done_nxt  = 1'b1;
				end
			end
			default: begin
				state_nxt = alsc_pkg::ST_IDLE;
			end
		endcase
	end

	// Sequencer registers
	always_ff @(posedge i_mclk or posedge i_rst) begin
		if (i_rst) begin
			state_r <= alsc_pkg::ST_IDLE;
			cfg_r   <= '0;
			done_r  <= 1'b0;
		end else begin
			state_r <= state_nxt;
			cfg_r   <= cfg_nxt;
			done_r  <= done_nxt;
		end
	end

	// ADC clock at the active gain
	alsc_clkdiv u_div (
		.i_mclk (i_mclk),
		.i_rst  (i_rst),
		.i_run  (o_busy),
		.i_gain (cfg_r.gain),
		.o_tick (tick)
	);

	// Phase length in ADC clocks
	alsc_count u_cnt (
		.i_mclk   (i_mclk),
		.i_rst    (i_rst),
		.i_load   (load),
		.i_len    (len),
		.i_tick   (tick),
		.o_last   (last)
	);

	// Status outputs
	assign o_busy       = (state_r != alsc_pkg::ST_IDLE);
	assign o_integrate  = (state_r == alsc_pkg::ST_INTEG);
	assign o_ir_meas    = o_busy && cfg_r.ir;
	assign o_high_range = o_busy && cfg_r.high_range;
	assign o_gain       = cfg_r.gain;
	assign o_adc_tick   = tick;
	assign o_done       = done_r;

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	logic [9:0] gap_r;
	logic       gap_ok_r;
	logic [8:0] tcnt_r;
	logic       ir_wr_r;
	// Helper counters for tick spacing and phase length
	always_ff @(posedge i_mclk or posedge i_rst) begin
		if (i_rst) begin
			gap_r    <= 10'h000;
			gap_ok_r <= 1'b0;
			tcnt_r   <= 9'h000;
			ir_wr_r  <= 1'b0;
		end else begin
			gap_r    <= tick ? 10'h000 : gap_r + 10'h001;
			gap_ok_r <= o_busy && (gap_ok_r || tick);
			if (load) begin
				tcnt_r <= 9'h000;
			end else if (tick) begin
				tcnt_r <= tcnt_r + 9'h001;
			end
			if (i_wr && (i_addr == alsc_pkg::OFS_IR_REC)) begin
				ir_wr_r <= 1'b1;
			end
		end
	end

	property p_tick_gap;
		@(posedge i_mclk) disable iff (i_rst)
		(tick && gap_ok_r) |->
			(gap_r == alsc_pkg::adc_div_cycles(cfg_r.gain) - 10'h001);
	endproperty
	a_tick_gap: assert property (p_tick_gap)
		else $error("ADC tick spacing wrong for gain");
	property p_integ_len;
		@(posedge i_mclk) disable iff (i_rst)
		(o_integrate && last) |->
			(tcnt_r + 9'h001 == alsc_pkg::INTEG_ADC_CLKS) ##1 o_done;
	endproperty
	a_integ_len: assert property (p_integ_len)
		else $error("Integration length wrong");
	property p_rec_len;
		@(posedge i_mclk) disable iff (i_rst)
		(state_r == alsc_pkg::ST_RECOVER && last) |->
			(tcnt_r + 9'h001 == alsc_pkg::rec_len(cfg_r.rec_code))
			##1 o_integrate;
	endproperty
	a_rec_len: assert property (p_rec_len)
		else $error("Recovery length wrong");
	property p_gain_wr;
		@(posedge i_mclk) disable iff (i_rst)
		(i_wr && i_addr == alsc_pkg::OFS_VIS_GAIN) |=>
			(vis_gain_r == $past(i_wdata[2:0]));
	endproperty
	a_gain_wr: assert property (p_gain_wr)
		else $error("Visible gain not stored");
	property p_visible_signal_range;
		@(posedge i_mclk) disable iff (i_rst)
		(!o_busy && start_vis) |=>
			(o_high_range == $past(visible_signal_range_r)) && !o_ir_meas;
	endproperty
	a_visible_signal_range: assert property (p_visible_signal_range)
		else $error("Visible range not applied");
	property p_ir_cfg;
		@(posedge i_mclk) disable iff (i_rst)
		(!o_busy && start_ir && !start_vis) |=>
			o_ir_meas && (o_gain == (LATER_REV ? $past(ir_gain_r) :
			$past(vis_gain_r))) && (cfg_r.rec_code == (LATER_REV ?
			$past(ir_rec_r) : 3'h7));
	endproperty
	a_ir_cfg: assert property (p_ir_cfg)
		else $error("Infrared settings wrong for revision");
	property p_ir_rst;
		@(posedge i_mclk) disable iff (i_rst)
		!ir_wr_r |-> (ir_rec_r == alsc_pkg::RST_IR_REC[6:4]);
	endproperty
	a_ir_rst: assert property (p_ir_rst)
		else $error("Infrared recovery reset value lost");
	property p_ir_rd;
		@(posedge i_mclk) disable iff (i_rst)
		(i_rd && i_addr == alsc_pkg::OFS_IR_REC) |=>
			(o_rdata == (LATER_REV ? {1'b0, $past(ir_rec_r), 4'h0} :
			8'h00));
	endproperty
	a_ir_rd: assert property (p_ir_rd)
		else $error("Infrared recovery read wrong");

endmodule

`default_nettype wire

// *** verif/alsc_top_tb.sv ***
// Self-checking testbench for the ambient light ADC configuration block
`timescale 1ns/100ps
`default_nettype none

module alsc_top_tb;

	// ------------------------------------------------------------
	// Signals and instances
	// ------------------------------------------------------------
	logic        i_mclk, i_rst, i_wr, i_rd, en_e, sel_e, hb;
	logic  [7:0] i_addr, i_wdata, rdata, e_rdata, seed, d, de;
	logic        tick, busy, integ, ir, hr, done;
	logic        e_tick, e_busy, e_integ, e_ir, e_hr, e_done;
	logic  [2:0] gain, e_gain, gv;
	logic [31:0] mismatches, checked, cyc, bc, ic, tc;
	int          n;
	logic  [7:0] wl [7] = '{8'h11, 8'h12, 8'h1F, 8'h1D, 8'h1E, 8'h13, 8'h30};
	logic  [7:0] rl [8] = '{8'h11, 8'h12, 8'h1C, 8'h1D, 8'h1E, 8'h20, 8'h21,
		8'h30};
	logic  [2:0] vg [3] = '{3'h0, 3'h4, 3'h6};
	wire         wr_e   = i_wr & en_e;
	wire         busy_m = sel_e ? e_busy : busy;
	wire         int_m  = sel_e ? e_integ : integ;
	wire         tick_m = sel_e ? e_tick : tick;
	wire         done_m = sel_e ? e_done : done;
	wire  [4:0]  set_m  = sel_e ? {e_ir, e_hr, e_gain} : {ir, hr, gain};

	alsc_top uut (.i_mclk(i_mclk), .i_rst(i_rst), .i_addr(i_addr),
		.i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(rdata),
		.o_adc_tick(tick), .o_busy(busy), .o_integrate(integ),
		.o_ir_meas(ir), .o_high_range(hr), .o_gain(gain), .o_done(done));

	alsc_top #(.LATER_REV(1'b0)) uut_early (.i_mclk(i_mclk), .i_rst(i_rst),
		.i_addr(i_addr), .i_wdata(i_wdata), .i_wr(wr_e), .i_rd(i_rd),
		.o_rdata(e_rdata), .o_adc_tick(e_tick), .o_busy(e_busy),
		.o_integrate(e_integ), .o_ir_meas(e_ir), .o_high_range(e_hr),
		.o_gain(e_gain), .o_done(e_done));

	// Clock
	initial begin
		i_mclk = 1'b0;
		forever #4 i_mclk = ~i_mclk;
	end

	// Phase counters of the watched instance and the hang limit
	always @(posedge i_mclk) begin
		cyc <= cyc + 1;
		if (busy_m) bc <= bc + 1;
		if (int_m) ic <= ic + 1;
		if (tick_m & busy_m) tc <= tc + 1;
		if (cyc == 32'd90000) begin
			mismatches = mismatches + 1;
			tally_and_finish();
		end
	end

	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------
	function automatic logic [7:0] lfsr(input logic [7:0] s);
		return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
	endfunction

	// Bits that a register keeps
	function automatic logic [7:0] msk(input logic [7:0] a, input logic e);
		case (a)
			8'h11: return 8'h07;
			8'h12: return 8'h20;
			8'h1C: return 8'hFF;
			8'h1D: return e ? 8'h00 : 8'h70;
			8'h1E: return e ? 8'h00 : 8'h07;
			default: return 8'h00;
		endcase
	endfunction

	function automatic logic [7:0] rstv(input logic [7:0] a, input logic e);
		return (a == 8'h1D && !e) ? 8'h70 : 8'h00;
	endfunction

	// Recovery length in ADC clocks
	function automatic logic [31:0] rec_exp(input logic [2:0] c);
		return (c == 3'h0) ? 32'h1 : (32'h4 << c) - 32'h1;
	endfunction

	task automatic check(input logic [31:0] got, exp, input string what);
		checked = checked + 1;
		if (got !== exp) begin
			mismatches = mismatches + 1;
			$display("wrong value at %0t: %s got %0h expected %0h",
				$time, what, got, exp);
		end
	endtask

	task automatic wr_reg(input logic [7:0] a, dat);
		@(posedge i_mclk);
		i_addr <= a;
		i_wdata <= dat;
		i_wr <= 1'b1;
		@(posedge i_mclk);
		i_wr <= 1'b0;
	endtask

	task automatic rd_reg(input logic [7:0] a, output logic [7:0] q, qe);
		@(posedge i_mclk);
		i_addr <= a;
		i_rd <= 1'b1;
		@(posedge i_mclk);
		i_rd <= 1'b0;
		@(negedge i_mclk);
		q = rdata;
		qe = e_rdata;
	endtask

	task automatic check_resets();
		for (int k = 0; k < 8; k++) begin
			rd_reg(rl[k], d, de);
			check(d, rstv(rl[k], 1'b0), "reset value");
			check(de, rstv(rl[k], 1'b1), "early reset value");
		end
	endtask

	// One whole measurement on the watched instance
	task automatic measure(input logic irm, input logic [2:0] g,
		input logic h, input logic [2:0] code);
		logic [7:0]  s, se;
		logic [31:0] p, t;
		int          w;
		p = 32'd7 << g;
		t = rec_exp(code) + 32'd64;
		@(negedge i_mclk);
		bc = 0;
		ic = 0;
		tc = 0;
		wr_reg(8'h21, {6'h00, irm, ~irm});
		rd_reg(8'h20, s, se);
		check(sel_e ? se : s, {5'h00, irm, 2'h1}, "status");
		check(set_m, {irm, h, g}, "latched settings");
		wr_reg(8'h21, 8'h03);
		w = 0;
		while (done_m !== 1'b1 && w < 40000) begin
			@(negedge i_mclk);
			w++;
		end
		check({done_m, busy_m}, 2'h2, "done as busy ends");
		w = 0;
		while ((busy | e_busy) !== 1'b0 && w < 40000) begin
			@(negedge i_mclk);
			w++;
		end
		check(bc, t * p + 1, "busy cycles");
		check(ic, p * 64, "integration cycles");
		check(tc, t, "adc ticks");
	endtask

	task automatic tally_and_finish();
		$display("checked %0d mismatches %0d", checked, mismatches);
		if (mismatches == 0 && checked > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	initial begin
		i_rst = 1'b1;
		i_wr = 1'b0;
		i_rd = 1'b0;
		i_addr = 8'h00;
		i_wdata = 8'h00;
		en_e = 1'b1;
		sel_e = 1'b0;
		mismatches = 0;
		checked = 0;
		cyc = 0;
		bc = 0;
		ic = 0;
		tc = 0;
		seed = 8'h2E;
		repeat (20) @(posedge i_mclk);
		i_rst <= 1'b0;
		check_resets();
		// Random write and read back, both revisions
		for (int k = 0; k < 7; k++) begin
			seed = lfsr(seed);
			wr_reg(wl[k], (msk(wl[k], 1'b0) == 8'h00) ? seed :
				seed & msk(wl[k], 1'b0));
			rd_reg(wl[k], d, de);
			check(d, seed & msk(wl[k], 1'b0), "readback");
			check(de, seed & msk(wl[k], 1'b1), "early readback");
		end
		wr_reg(8'h1C, 8'h00);
		en_e <= 1'b0;
		// Visible gains with both ranges
		for (int k = 0; k < 3; k++) begin
			seed = lfsr(seed);
			hb = (k == 0) ? 1'b0 : (k == 1) ? 1'b1 : seed[0];
			gv = vg[k];
			wr_reg(8'h11, {5'h00, gv});
			wr_reg(8'h12, {2'h0, hb, 5'h00});
			measure(1'b0, gv, hb, 3'h0);
		end
		// Every recovery code with visible settings at their extremes
		wr_reg(8'h11, 8'h07);
		wr_reg(8'h12, 8'h20);
		for (int c = 0; c < 8; c++) begin
			gv = (c == 0) ? 3'h1 : 3'h0;
			wr_reg(8'h1E, {5'h00, gv});
			wr_reg(8'h1D, {1'b0, 3'(c), 4'h0});
			measure(1'b1, gv, 1'b0, 3'(c));
		end
		// Largest gain: first tick spacing, then reset mid-run
		wr_reg(8'h21, 8'h01);
		@(negedge i_mclk);
		n = 0;
		while (busy !== 1'b1 && n < 10) begin
			@(negedge i_mclk);
			n++;
		end
		n = 0;
		while (tick !== 1'b1 && n < 2000) begin
			@(negedge i_mclk);
			n++;
		end
		check(32'(n), 32'd896, "first tick");
		check(gain, 3'h7, "largest gain");
		@(posedge i_mclk);
		i_rst <= 1'b1;
		@(negedge i_mclk);
		check({busy, integ, done, tick}, 4'h0, "outputs in reset");
		repeat (2) @(posedge i_mclk);
		i_rst <= 1'b0;
		check_resets();
		// Early revision: infrared follows visible settings
		en_e = 1'b1;
		sel_e = 1'b1;
		wr_reg(8'h11, 8'h02);
		wr_reg(8'h12, 8'h20);
		wr_reg(8'h1D, 8'h00);
		measure(1'b1, 3'h2, 1'b1, 3'h7);
		tally_and_finish();
	end

endmodule

`default_nettype wire
